// ### src/fis_pkg.sv
// constants, opcodes and carrier types of the flash id/suspend/security-register command block
package fis_pkg;

    // core clock and self-timed cycle lengths
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned WAKE_DELAY_NS = 20000;
    localparam int unsigned SECREG_ERASE_TIME_NS = 100000;
    localparam int unsigned PAGE_PROG_TIME_NS = 50000;
    localparam int unsigned RESUME_MAX_NS = 200;

    // opcodes
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
    localparam logic [7:0] OP_MAKER_PART = 8'h90;
    localparam logic [7:0] OP_IDENT = 8'h9F;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
    localparam logic [7:0] OP_SECREG_PROG = 8'h42;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK = 8'h04;

    // frame lengths in bits
    localparam logic [15:0] OP_BITS = 16'h0008;
    localparam logic [15:0] ADDR3_BITS = 16'h0018;
    localparam logic [15:0] ADDR4_BITS = 16'h0020;
    localparam logic [15:0] DUMMY_BITS = 16'h0008;
    localparam logic [15:0] DATA_BITS = 16'h0008;
    localparam logic [15:0] BITS_MAX = 16'hFFFF;

    // identification output lengths
    localparam logic [15:0] IDENT_BITS = 16'h0018;

    // security register address fields
    localparam int unsigned SEL_LSB = 12;
    localparam int unsigned PAGE_LSB = 8;
    localparam int unsigned HIGH_LSB = 16;
    localparam logic [3:0] SEL_FIRST = 4'h1;
    localparam logic [3:0] SEL_LAST = 4'h3;

    typedef enum {ST_IDLE, ST_WAKE, ST_SECREG_ERASE, ST_SECREG_PROG} fis_state_t;

    // one finished frame as seen at the select rise
    typedef struct packed {
        logic [7:0] op;
        logic [31:0] addr;
        logic [15:0] bits;
    } fis_frame_t;

    // security register operation started by the block
    typedef struct packed {
        logic erase;
        logic [1:0] sel;
        logic [3:0] page;
        logic [7:0] byte_addr;
    } fis_secreg_t;

    // least time rounds up to whole cycles, never below one
    function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction : ns_to_cyc_up

endpackage : fis_pkg

// ### src/fis_cmd.sv
// command handling for wake, id reads, suspend/resume and security register erase/program
// Operation
// - after wake, ignore commands until delay ends; id reads still put out data during the delay
// - wake ignored while busy flag set
// - unique id: opcode, zero address, dummy, 128 bits
// - address 24 bits, 32 in four-byte mode
// - maker/part read: opcode, 24-bit address, two codes
// - ident read: maker, memory type, capacity bytes
// - ident read not decoded during busy cycle
// - select rise ends id output, back to standby
// - suspend only when main op busy, flags clear
// - suspend flag at once, busy cleared within latency
// - program suspend refuses writes, erases, programs
// - erase suspend refuses writes, erases, lock commands
// - power removal resets device and suspend state
// - resume clears flag, sets busy within 200ns
// - secreg erase only if select rises after address
// - secreg erase busy, write latch cleared before end
// - security lock bit blocks secreg erase
// - register chosen by address bits 15..12, 1..3
// - sixteen pages, page bits 11..8, byte 7..0
// - secreg program: address, data, write latch needed
// - security lock bit blocks secreg program
// - deep sleep accepts only wake and reset pair
`timescale 1ns/1ns
module fis_cmd
    import fis_pkg::*;
#(
    parameter int unsigned WAKE_CYC = ns_to_cyc_up(WAKE_DELAY_NS),
    parameter int unsigned SECREG_ERASE_CYC = ns_to_cyc_up(SECREG_ERASE_TIME_NS),
    parameter int unsigned PAGE_PROG_CYC = ns_to_cyc_up(PAGE_PROG_TIME_NS),
    parameter int unsigned CNT_W = 24,
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] PART_CODE = 8'h19,
    parameter logic [7:0] MEM_TYPE = 8'h61,
    parameter logic [7:0] CAPACITY = 8'h1A,
    parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
    // core clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // configuration and main-array engine
    input wire logic addr4_mode_i,
    input wire logic secreg_lock_i,
    input wire logic main_busy_i,
    input wire logic main_is_erase_i,
    // status
    output logic busy_flag_o,
    output logic write_latch_flag_o,
    output logic suspend_flag_one_o,
    output logic suspend_flag_two_o,
    output logic deep_sleep_o,
    // requests to the rest of the device
    output logic suspend_req_o,
    output logic resume_req_o,
    output logic secreg_start_o,
    output fis_secreg_t secreg_op_o,
    output logic cmd_valid_o,
    output fis_frame_t cmd_frame_o,
    output logic cmd_refused_o
);

    if (WAKE_CYC < 1 || SECREG_ERASE_CYC < 1 || PAGE_PROG_CYC < 1) begin : g_bad_cyc
        $error("cycle counts must be at least one");
    end
    if (CNT_W < 2 || CNT_W > 31 || WAKE_CYC >= (1 << CNT_W) ||
        SECREG_ERASE_CYC >= (1 << CNT_W) || PAGE_PROG_CYC >= (1 << CNT_W)) begin : g_bad_w
        $error("timer width cannot hold the cycle counts");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift in on rising sclk, shift out on falling sclk

    logic [15:0] bits_q;
    logic [15:0] frame_bits_q;
    logic [7:0] op_q;
    logic [31:0] addr_q;
    logic [2:0] lk_meta_q;
    logic [2:0] lk_sync_q;
    logic miso_q;
    logic miso_oe_q;
    logic busy_q;
    logic deep_sleep_q;
    logic [15:0] lk_alen;
    logic [15:0] out_idx;
    logic out_act;
    logic out_bit;

    // {four-byte mode, busy, deep sleep} into the link clock
    always_ff @(posedge sclk_i) begin
        lk_meta_q <= {addr4_mode_i, busy_q, deep_sleep_q};
        lk_sync_q <= lk_meta_q;
    end

    assign lk_alen = lk_sync_q[2] ? ADDR4_BITS : ADDR3_BITS;

    // a raised select clears the frame position at once
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bits_q <= '0;
        end else if (bits_q != BITS_MAX) begin
            bits_q <= bits_q + 16'h0001;
        end
    end

    // captured fields stay put after select rises, the core reads them then
    always_ff @(posedge sclk_i) begin
        if (bits_q != BITS_MAX) begin
            frame_bits_q <= bits_q + 16'h0001;
        end
        if (bits_q < OP_BITS) begin
            op_q <= {op_q[6:0], mosi_i};
        end else if (bits_q < OP_BITS + lk_alen) begin
            addr_q <= {addr_q[30:0], mosi_i};
        end
    end

    always_comb begin
        out_act = 1'b0;
        out_idx = '0;
        out_bit = 1'b0;
        if (bits_q >= OP_BITS && !lk_sync_q[0]) begin
            unique case (op_q)
                OP_IDENT: begin
                    out_idx = bits_q - OP_BITS;
                    out_act = !lk_sync_q[1] && out_idx < IDENT_BITS;
                    out_bit = out_act && 1'({MAKER_CODE, MEM_TYPE, CAPACITY} >>
                                            (IDENT_BITS - 16'h0001 - out_idx));
                end
                OP_MAKER_PART: begin
                    out_idx = bits_q - OP_BITS - ADDR3_BITS;
                    out_act = bits_q >= OP_BITS + ADDR3_BITS;
                    out_bit = 1'({MAKER_CODE, PART_CODE} >> (4'hF - out_idx[3:0]));
                end
                OP_UNIQUE_ID: begin
                    out_idx = bits_q - OP_BITS - lk_alen - DUMMY_BITS;
                    out_act = bits_q >= OP_BITS + lk_alen + DUMMY_BITS;
                    out_bit = UNIQUE_ID[7'h7F - out_idx[6:0]];
                end
                default: begin
                    out_act = 1'b0;
                end
            endcase
        end
    end

    // select high releases the data line at once
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            miso_q <= out_bit;
            miso_oe_q <= out_act;
        end
    end

    assign miso_o = miso_q;
    assign miso_oe_o = miso_oe_q;

    ////////////////////////////////////////////////////////////////////////////////
    // core domain: frame end detection and decode

    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    logic frame_end;
    fis_frame_t fr;
    logic [15:0] alen;
    logic [31:0] addr_m;
    logic hdr_ok;
    logic live;
    logic do_wake;
    logic do_sleep;
    logic do_reset_en;
    logic do_reset;
    logic do_write_unlock_cmd;
    logic do_wrdi;
    logic do_se;
    logic do_pp;
    logic do_sus;
    logic do_res;
    logic refused;
    logic handled;
    logic reset_armed_q;
    logic write_latch_q;
    logic sus_one_q;
    logic sus_two_q;
    logic resume_hold_q;
    fis_state_t state_q;
    logic [CNT_W-1:0] timer_q;

    // commands refused while a main-array operation is suspended
    function automatic logic is_refused(input logic [7:0] op, input logic sus_prog,
                                        input logic sus_erase);
        logic wr_stat;
        logic erase;
        logic prog;
        logic lock_cmd;
        wr_stat = op inside {8'h01, 8'h11, 8'hB1, 8'hAA, 8'h55};
        erase = op inside {8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'h60, 8'hC7};
        prog = op inside {8'h02, 8'h12, 8'h32, 8'h34};
        lock_cmd = op inside {8'h50, 8'hE1, 8'hE3, 8'hE4, 8'h7E, 8'h98};
        return (sus_prog && (wr_stat || erase || prog || op == OP_SECREG_ERASE ||
                             op == OP_SECREG_PROG)) ||
               (sus_erase && (wr_stat || erase || lock_cmd ||
                              op == OP_SECREG_ERASE));
    endfunction : is_refused

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cs_meta_q <= cs_n_i;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    assign frame_end = cs_sync_q && !cs_prev_q;
    assign fr = '{op: op_q, addr: addr_q, bits: frame_bits_q};

    always_comb begin
        alen = addr4_mode_i ? ADDR4_BITS : ADDR3_BITS;
        addr_m = addr4_mode_i ? fr.addr : {8'h00, fr.addr[23:0]};
        hdr_ok = addr_m[31:HIGH_LSB] == '0 &&
                 addr_m[SEL_LSB+3:SEL_LSB] >= SEL_FIRST &&
                 addr_m[SEL_LSB+3:SEL_LSB] <= SEL_LAST;
        live = frame_end && fr.bits >= OP_BITS && !deep_sleep_q && state_q != ST_WAKE;
        do_wake = frame_end && fr.bits == OP_BITS && fr.op == OP_WAKE &&
                  deep_sleep_q && !busy_q;
        do_reset_en = frame_end && fr.bits == OP_BITS && fr.op == OP_RESET_ENABLE &&
                      state_q != ST_WAKE;
        do_reset = frame_end && fr.bits == OP_BITS && fr.op == OP_RESET &&
                   reset_armed_q && state_q != ST_WAKE;
        do_sleep = live && fr.bits == OP_BITS && fr.op == OP_DEEP_SLEEP && !busy_q;
        do_write_unlock_cmd = live && fr.bits == OP_BITS && fr.op == OP_WRITE_UNLOCK && !busy_q;
        do_wrdi = live && fr.bits == OP_BITS && fr.op == OP_WRITE_LOCK && !busy_q;
        refused = live && !busy_q && is_refused(fr.op, sus_two_q, sus_one_q);
        do_se = live && fr.op == OP_SECREG_ERASE && fr.bits == OP_BITS + alen &&
                write_latch_q && !secreg_lock_i && !busy_q && hdr_ok && !refused;
        do_pp = live && fr.op == OP_SECREG_PROG &&
                fr.bits >= OP_BITS + alen + DATA_BITS &&
                write_latch_q && !secreg_lock_i && !busy_q && hdr_ok && !refused;
        do_sus = live && fr.bits == OP_BITS && fr.op == OP_SUSPEND && main_busy_i &&
                 !resume_hold_q && !sus_one_q && !sus_two_q;
        do_res = live && fr.bits == OP_BITS && fr.op == OP_RESUME &&
                 (sus_one_q || sus_two_q) && !busy_q;
        handled = fr.op inside {OP_WAKE, OP_DEEP_SLEEP, OP_RESET_ENABLE, OP_RESET,
                                OP_UNIQUE_ID, OP_MAKER_PART, OP_IDENT, OP_SUSPEND,
                                OP_RESUME, OP_SECREG_ERASE, OP_SECREG_PROG,
                                OP_WRITE_UNLOCK, OP_WRITE_LOCK};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed cycles: wake delay, security register erase and program

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (do_wake) begin
                        state_q <= ST_WAKE;
                        timer_q <= CNT_W'(WAKE_CYC - 1);
                    end else if (do_se) begin
                        state_q <= ST_SECREG_ERASE;
                        timer_q <= CNT_W'(SECREG_ERASE_CYC - 1);
                    end else if (do_pp) begin
                        state_q <= ST_SECREG_PROG;
                        timer_q <= CNT_W'(PAGE_PROG_CYC - 1);
                    end
                end
                ST_WAKE, ST_SECREG_ERASE, ST_SECREG_PROG: begin
                    if (timer_q == '0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        timer_q <= timer_q - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // deep sleep and the reset-enable/reset pair

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            deep_sleep_q <= 1'b0;
            reset_armed_q <= 1'b0;
        end else begin
            if (do_sleep) begin
                deep_sleep_q <= 1'b1;
            end else if (do_wake || do_reset) begin
                deep_sleep_q <= 1'b0;
            end
            if (frame_end && fr.bits >= OP_BITS) begin
                reset_armed_q <= do_reset_en;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write latch and busy flag

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            write_latch_q <= 1'b0;
        end else if (do_se || do_pp || do_wrdi || do_reset) begin
            write_latch_q <= 1'b0;
        end else if (do_write_unlock_cmd) begin
            write_latch_q <= 1'b1;
        end
    end

    // resume holds busy until the engine picks the operation up again
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            resume_hold_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            if (do_res) begin
                resume_hold_q <= 1'b1;
            end else if (main_busy_i) begin
                resume_hold_q <= 1'b0;
            end
            busy_q <= do_se || do_pp || do_res || main_busy_i ||
                      (resume_hold_q && !main_busy_i) ||
                      ((state_q == ST_SECREG_ERASE || state_q == ST_SECREG_PROG) &&
                       timer_q != '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // suspend flags: one for erase, two for program

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sus_one_q <= 1'b0;
            sus_two_q <= 1'b0;
        end else if (do_sus) begin
            sus_one_q <= main_is_erase_i;
            sus_two_q <= !main_is_erase_i;
        end else if (do_res) begin
            sus_one_q <= 1'b0;
            sus_two_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request outputs

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            suspend_req_o <= 1'b0;
            resume_req_o <= 1'b0;
            secreg_start_o <= 1'b0;
            secreg_op_o <= '0;
            cmd_valid_o <= 1'b0;
            cmd_frame_o <= '0;
            cmd_refused_o <= 1'b0;
        end else begin
            suspend_req_o <= do_sus;
            resume_req_o <= do_res;
            secreg_start_o <= do_se || do_pp;
            if (do_se || do_pp) begin
                secreg_op_o <= '{erase: do_se,
                                 sel: addr_m[SEL_LSB+1:SEL_LSB],
                                 page: do_se ? 4'h0 : addr_m[PAGE_LSB+3:PAGE_LSB],
                                 byte_addr: do_se ? 8'h00 : addr_m[7:0]};
            end
            cmd_refused_o <= refused;
            cmd_valid_o <= live && !handled && !refused;
            if (live && !handled && !refused) begin
                cmd_frame_o <= '{op: fr.op, addr: addr_m, bits: fr.bits};
            end
        end
    end

    assign busy_flag_o = busy_q;
    assign write_latch_flag_o = write_latch_q;
    assign suspend_flag_one_o = sus_one_q;
    assign suspend_flag_two_o = sus_two_q;
    assign deep_sleep_o = deep_sleep_q;

endmodule : fis_cmd

// ### verif/fis_cmd_sva.sv
// assertions on the ports of the command block
`timescale 1ns/1ns
module fis_cmd_sva
    import fis_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // inputs
    input wire logic cs_n_i,
    input wire logic secreg_lock_i,
    input wire logic main_busy_i,
    input wire logic main_is_erase_i,
    // outputs
    input wire logic miso_oe_o,
    input wire logic busy_flag_o,
    input wire logic write_latch_flag_o,
    input wire logic suspend_flag_one_o,
    input wire logic suspend_flag_two_o,
    input wire logic deep_sleep_o,
    input wire logic suspend_req_o,
    input wire logic resume_req_o,
    input wire logic secreg_start_o,
    input wire fis_secreg_t secreg_op_o,
    input wire logic cmd_valid_o,
    input wire logic cmd_refused_o
);
default clocking cb @(posedge mclk_i); endclocking
default disable iff (reset_i);
////////////////////////////////////////
property p_start; secreg_start_o |-> busy_flag_o && !write_latch_flag_o; endproperty
a_start: assert property (p_start) else $error("start without busy");
property p_lock; secreg_start_o |-> !$past(secreg_lock_i); endproperty
a_lock: assert property (p_lock) else $error("start while locked");
property p_sel; secreg_start_o |-> secreg_op_o.sel != 2'h0; endproperty
a_sel: assert property (p_sel) else $error("bad register select");
property p_sus; suspend_req_o |-> $past(main_busy_i) && !$past(suspend_flag_one_o)
    && !$past(suspend_flag_two_o) && (suspend_flag_one_o ^ suspend_flag_two_o); endproperty
a_sus: assert property (p_sus) else $error("bad suspend");
property p_sus_kind; suspend_req_o |-> suspend_flag_one_o == $past(main_is_erase_i); endproperty
a_sus_kind: assert property (p_sus_kind) else $error("wrong suspend flag");
property p_res; resume_req_o |-> busy_flag_o && !suspend_flag_one_o && !suspend_flag_two_o
    && ($past(suspend_flag_one_o) || $past(suspend_flag_two_o)); endproperty
a_res: assert property (p_res) else $error("bad resume");
property p_oe; cs_n_i |-> !miso_oe_o; endproperty
a_oe: assert property (p_oe) else $error("output on while deselected");
property p_ref; cmd_refused_o |-> suspend_flag_one_o || suspend_flag_two_o; endproperty
a_ref: assert property (p_ref) else $error("refusal without suspend");
property p_sleep; deep_sleep_o |-> !(secreg_start_o || suspend_req_o || resume_req_o
    || cmd_valid_o || cmd_refused_o); endproperty
a_sleep: assert property (p_sleep) else $error("command acted in sleep");
endmodule : fis_cmd_sva
bind fis_cmd fis_cmd_sva i_sva (.*);

// ### verif/fis_host.sv
// host controller model driving the serial link
`timescale 1ns/1ns
module fis_host (
    // serial link
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
end
// n_in bits out msb first, then n_out bits read on rising edges
task automatic frame(input logic [63:0] d, input int n_in, input int n_out,
    output logic [127:0] q);
    q = '0;
    cs_n_o = 1'b0;
    for (int i = 0; i < n_in + n_out; i++) begin
        mosi_o = (i < n_in) ? d[n_in - 1 - i] : ~mosi_o;
        #62 sclk_o = 1'b1;
        if (i >= n_in) q = {q[126:0], miso_i};
        #63 sclk_o = 1'b0;
    end
    #62 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #100; // select stays high well past the decode and only just past the bench's 20-cycle wake delay
endtask : frame
endmodule : fis_host

// ### verif/fis_cmd_tb_top.sv
// self-checking bench for the command block
`timescale 1ns/1ns
module fis_cmd_tb_top;
import fis_pkg::*;
////////////////////////////////////////
// identity values are arbitrary
localparam logic [7:0] MK = 8'h3C;
localparam logic [7:0] PC = 8'h47;
localparam logic [7:0] MT = 8'h52;
localparam logic [7:0] CP = 8'h18;
localparam logic [127:0] UID = 128'hA5A5_0F0F_1234_5678_9ABC_DEF0_C3C3_7E81;
localparam logic [19:0] EV_ST = 20'h08000;
localparam logic [19:0] EV_SUS = 20'h10000;
localparam logic [19:0] EV_RES = 20'h20000;
localparam logic [19:0] EV_REF = 20'h80000;
localparam logic [19:0] EV_CV = 20'h40000;
localparam logic [63:0] RD[11] = '{64'h44002000, 64'h50, 64'h7E, 64'h98, 64'hC7,
    64'h20000000, 64'h0100, 64'h44002000, 64'h4200200000, 64'h0200000000, 64'h60};
localparam int RN[11] = '{32, 8, 8, 8, 8, 32, 16, 32, 40, 40, 8};
logic mclk_i = 1'b0;
logic reset_i = 1'b1;
logic lock = 1'b0;
logic mbusy = 1'b0;
logic merase = 1'b0;
logic a4 = 1'b0;
logic sclk, cs_n, mosi, miso, oe, busy, wl, s1, s2, dsl, sreq, rreq, st, cv, cr;
fis_secreg_t sop;
fis_frame_t cfr;
int n_errors = 0;
int samples_checked = 0;
int cyc = 0;
logic [31:0] rs = 32'h0000CE8F;
logic [127:0] q;
logic [19:0] expq[$];
// pull-up on the data-out line
wire miso_w = (oe === 1'b1) ? miso : 1'b1;
initial forever #2 mclk_i = ~mclk_i;
fis_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
fis_cmd #(.WAKE_CYC(20), .SECREG_ERASE_CYC(40), .PAGE_PROG_CYC(30), .MAKER_CODE(MK),
    .PART_CODE(PC), .MEM_TYPE(MT), .CAPACITY(CP), .UNIQUE_ID(UID)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(oe), .addr4_mode_i(a4), .secreg_lock_i(lock),
    .main_busy_i(mbusy), .main_is_erase_i(merase), .busy_flag_o(busy),
    .write_latch_flag_o(wl), .suspend_flag_one_o(s1), .suspend_flag_two_o(s2),
    .deep_sleep_o(dsl), .suspend_req_o(sreq), .resume_req_o(rreq), .secreg_start_o(st),
    .secreg_op_o(sop), .cmd_valid_o(cv), .cmd_frame_o(cfr), .cmd_refused_o(cr));
////////////////////////////////////////
function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
endfunction : xs
task automatic chk(string nm, logic [127:0] s, logic [127:0] e);
    samples_checked++;
    if (s !== e) begin
        n_errors++;
        $display("MISMATCH %s exp %0h seen %0h", nm, e, s);
    end
endtask : chk
task automatic go(logic [63:0] d, int n, int no);
    i_host.frame(d, n, no, q);
endtask : go
task automatic sync;
    @(posedge mclk_i);
    #1;
endtask : sync
task automatic wait_idle;
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge mclk_i);
    chk("busy_done", busy, 1'b0);
endtask : wait_idle
task automatic give_verdict;
    n_errors += expq.size();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask : give_verdict
////////////////////////////////////////
// every pulse must match the oldest expected note
always @(negedge mclk_i) begin
    if (!reset_i && (cr | cv | rreq | sreq | st) !== 1'b0) begin
        if (expq.size() == 0) chk("stray", {cr, cv, rreq, sreq, st}, 5'h0);
        else chk("event", {cr, cv, rreq, sreq, st, st ? sop : 15'h0}, expq.pop_front());
    end
end
always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
        n_errors++;
        give_verdict();
    end
end
initial begin
    repeat (12) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    go(64'h06, 8, 0);
    chk("latch", wl, 1'b1);
    expq.push_back(EV_ST | 20'h06000);
    go({8'h44, 24'h002000}, 32, 0);
    chk("busy_latch", {busy, wl}, 2'b10);
    wait_idle();
    go(64'h06, 8, 0);
    go({8'h44, 32'h00200000}, 40, 0);
    sync;
    lock = 1'b1;
    go({8'h44, 24'h003000}, 32, 0);
    go({8'h42, 24'h001000, 8'h5A}, 40, 0);
    chk("locked", busy, 1'b0);
    sync;
    lock = 1'b0;
    for (int i = 1; i < 4; i++) begin
        rs = xs(rs);
        expq.push_back(EV_ST | {1'b0, 2'(i), rs[11:0]});
        go(64'h06, 8, 0);
        go({8'h42, 10'h0, 2'(i), rs[11:0], rs[23:16]}, 40, 0);
        wait_idle();
    end
    go(64'h9F, 8, 12);
    chk("ident_cut", q[11:0], {MK, MT[7:4]});
    go(64'h9F, 8, 24);
    chk("ident", q[23:0], {MK, MT, CP});
    go({8'h90, 24'h0}, 32, 32);
    chk("maker_part", q[31:0], {MK, PC, MK, PC});
    sync;
    a4 = 1'b1;
    go({8'h4B, 40'h0}, 48, 128);
    chk("unique_id", q, UID);
    sync;
    a4 = 1'b0;
    expq.push_back(EV_CV);
    go({8'h03, 24'h123456}, 32, 0);
    chk("frame", cfr, {8'h03, 32'h00123456, 16'h0020});
    sync;
    mbusy = 1'b1;
    merase = 1'b1;
    go(64'h9F, 8, 8);
    chk("ident_busy", q[7:0], 8'hFF);
    go(64'hAB, 8, 0);
    expq.push_back(EV_SUS);
    go(64'h75, 8, 0);
    chk("sus_one", {s1, s2}, 2'b10);
    sync;
    mbusy = 1'b0;
    go(64'h75, 8, 0);
    go(64'h06, 8, 0);
    for (int k = 0; k < 6; k++) begin
        expq.push_back(EV_REF);
        go(RD[k], RN[k], 0);
    end
    expq.push_back(EV_RES);
    go(64'h7A, 8, 0);
    chk("resume", {busy, s1}, 2'b10);
    sync;
    mbusy = 1'b1;
    merase = 1'b0;
    expq.push_back(EV_SUS);
    go(64'h75, 8, 0);
    chk("sus_two", {s1, s2}, 2'b01);
    sync;
    mbusy = 1'b0;
    for (int k = 6; k < 11; k++) begin
        expq.push_back(EV_REF);
        go(RD[k], RN[k], 0);
    end
    sync;
    reset_i = 1'b1;
    sync;
    sync;
    reset_i = 1'b0;
    chk("power_off", {s1, s2, busy}, 3'b000);
    go(64'hB9, 8, 0);
    chk("sleep", dsl, 1'b1);
    go(64'h06, 8, 0); // write unlock is ignored while asleep
    chk("sleep_latch", wl, 1'b0);
    sync;
    mbusy = 1'b1;
    go(64'hAB, 8, 0);
    chk("wake_busy", dsl, 1'b1);
    sync;
    mbusy = 1'b0;
    go(64'hAB, 8, 0);
    chk("awake", dsl, 1'b0);
    go(64'h06, 8, 0);
    chk("latch_after_wake", wl, 1'b1);
    go(64'hB9, 8, 0);
    go(64'h66, 8, 0);
    go(64'h99, 8, 0);
    chk("reset_pair", {dsl, wl}, 2'b00);
    give_verdict();
end
endmodule : fis_cmd_tb_top
